// file: hdl/scd_top.sv
`timescale 1ns/1ps
`include "scd_defs.svh"
// system clock source select and power-of-two divider
module scd_top (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic osc_int_in,
  input wire logic osc_ext_in,
  input wire logic osc_rtc_in,
  input wire logic osc_lp_in,
  input wire logic osc_int_settled,
  input wire logic [6:0] trim_factory,
  output logic sysclk_out,
  output logic [1:0] sysclk_src_idx,
  output logic osc_int_on,
  output logic [6:0] osc_int_trim,
  output logic osc_dither_en
);

  // oscillator levels, one synchroniser each
  logic [3:0] osc_raw;
  logic [3:0] osc_lvl;
  logic [3:0] osc_chg;
  logic settled_lvl;

  // software-visible state
  scd_pkg::scd_div_code_t div_req_reg;
  scd_pkg::scd_src_code_t src_req_reg;
  logic osc_on_reg;
  logic freq_rdy_reg;
  logic [6:0] trim_reg;
  logic trim_loaded_reg;
  logic dither_reg;
  logic [7:0] rdata_reg;

  // clock generation state
  scd_pkg::scd_sw_state_t sw_state_reg;
  scd_pkg::scd_src_idx_t cur_src_reg;
  scd_pkg::scd_src_idx_t pend_src_reg;
  scd_pkg::scd_div_code_t div_act_reg;
  logic [6:0] half_cnt_reg;
  logic sysclk_reg;

  // combinational helpers
  logic req_valid;
  scd_pkg::scd_src_idx_t req_idx;
  logic [6:0] half_limit;
  logic cur_chg;
  logic cur_lvl;
  logic new_fall;
  logic count_en;
  logic hit;
  logic old_low_fall;
  logic toggle_en;
  logic exit_old;
  logic wr_src_div;
  logic wr_ctl;
  logic wr_trim;
  logic div_ready;
  logic osc_on_next;
  logic [7:0] rdata_next;

  // pin order matches the source index encoding
  assign osc_raw = {osc_lp_in, osc_rtc_in, osc_ext_in, osc_int_in};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_osc_sync
      scd_sync3 u_sync (
        .mclk(mclk),
        .arst_n(arst_n),
        .din(osc_raw[gi]),
        .level(osc_lvl[gi]),
        .change(osc_chg[gi])
      );
    end
  endgenerate

  // settled flag from the analog side, filtered like the clocks
  scd_sync3 u_settled_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .din(osc_int_settled),
    .level(settled_lvl),
    .change()
  );

  // register strobes
  assign wr_src_div = sfr_wr && (sfr_addr == `SCD_ADDR_SRC_DIV);
  assign wr_ctl = sfr_wr && (sfr_addr == `SCD_ADDR_IOSC_CTL);
  assign wr_trim = sfr_wr && (sfr_addr == `SCD_ADDR_IOSC_TRIM);

  // ready whenever the running divide equals the requested one
  // not sticky: writing back the running code shows ready at once
  assign div_ready = (div_act_reg == div_req_reg);

  // source code decode; reserved codes never start a switch
  always_comb begin
    req_valid = 1'b1;
    req_idx = `SCD_SRC_IDX_LP;
    case (src_req_reg)
      `SCD_SRC_CODE_INT: req_idx = `SCD_SRC_IDX_INT;
      `SCD_SRC_CODE_EXT: req_idx = `SCD_SRC_IDX_EXT;
      `SCD_SRC_CODE_RTC: req_idx = `SCD_SRC_IDX_RTC;
      `SCD_SRC_CODE_LP: req_idx = `SCD_SRC_IDX_LP;
      default: req_valid = 1'b0;
    endcase
  end

  // half periods of the source per divided half period: 2**code
  always_comb begin
    half_limit = 7'((8'h01 << div_act_reg) - 8'h01);
  end

  // edges of the running source and of the one being switched to
  always_comb begin
    cur_chg = osc_chg[cur_src_reg];
    cur_lvl = osc_lvl[cur_src_reg];
    new_fall = osc_chg[pend_src_reg] && !osc_lvl[pend_src_reg];
  end

  // count source half periods; frozen while waiting on the new source
  always_comb begin
    hit = (half_cnt_reg == half_limit);
    count_en = cur_chg && (sw_state_reg != scd_pkg::sw_wait_new);
  end

  // while draining, a falling old edge with output low ends the old source
  always_comb begin
    old_low_fall = cur_chg && !cur_lvl && !sysclk_reg;
    toggle_en = count_en && hit &&
                !((sw_state_reg == scd_pkg::sw_drain_old) && old_low_fall);
    // a counted toggle to low also leaves the old source cleanly
    exit_old = old_low_fall || (cur_chg && hit && sysclk_reg);
  end

  // source switch sequencer: run, drain old until output low on an old fall,
  // wait a fall of the new source, then run on it with the count cleared;
  // a request made mid-switch is taken once back in run
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sw_state_reg <= scd_pkg::sw_run;
      cur_src_reg <= `SCD_SRC_IDX_LP;
      pend_src_reg <= `SCD_SRC_IDX_LP;
    end else begin
      case (sw_state_reg)
        scd_pkg::sw_run: begin
          if (req_valid && (req_idx != cur_src_reg)) begin
            pend_src_reg <= req_idx;
            sw_state_reg <= scd_pkg::sw_drain_old;
          end
        end
        scd_pkg::sw_drain_old: begin
          if (exit_old) begin
            sw_state_reg <= scd_pkg::sw_wait_new;
          end
        end
        scd_pkg::sw_wait_new: begin
          if (new_fall) begin
            cur_src_reg <= pend_src_reg;
            sw_state_reg <= scd_pkg::sw_run;
          end
        end
        default: begin
          sw_state_reg <= scd_pkg::sw_run;
        end
      endcase
    end
  end

  // half-period counter and divide application
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      half_cnt_reg <= 7'h00;
      div_act_reg <= `SCD_DIV_RESET;
    end else begin
      // new source: restart the count and take any pending divide
      if ((sw_state_reg == scd_pkg::sw_wait_new) && new_fall) begin
        half_cnt_reg <= 7'h00;
        div_act_reg <= div_req_reg;
      end else if (count_en) begin
        if (hit) begin
          half_cnt_reg <= 7'h00;
          // new divide only at the end of a full output period
          if (sysclk_reg) begin
            div_act_reg <= div_req_reg;
          end
        end else begin
          half_cnt_reg <= 7'(half_cnt_reg + 7'h01);
        end
      end
    end
  end

  // divided system clock; moves only on counted source edges
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sysclk_reg <= 1'b0;
    end else if (toggle_en) begin
      sysclk_reg <= !sysclk_reg;
    end
  end

  // clock select and divider register
  // bit 3 has no storage, so it always reads back zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_req_reg <= `SCD_DIV_RESET;
      src_req_reg <= `SCD_SRC_RESET;
    end else if (wr_src_div) begin
      div_req_reg <= sfr_wdata[`SCD_POS_DIV +: 3];
      src_req_reg <= sfr_wdata[`SCD_POS_SRC +: 3];
    end
  end

  // enable as it stands after this edge; ready must drop with a disabling write
  always_comb begin
    osc_on_next = osc_on_reg;
    if (wr_ctl) begin
      osc_on_next = sfr_wdata[`SCD_BIT_IOSC_ON];
    end
  end

  // internal oscillator enable and ready
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      osc_on_reg <= 1'b0;
      freq_rdy_reg <= 1'b0;
    end else begin
      osc_on_reg <= osc_on_next;
      freq_rdy_reg <= osc_on_next && settled_lvl;
    end
  end

  // trim: factory value caught on the first edge after reset release
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      trim_reg <= `SCD_TRIM_PRELOAD;
      trim_loaded_reg <= 1'b0;
      dither_reg <= 1'b0;
    end else if (!trim_loaded_reg) begin
      // a trim write on this first edge loses to the strap
      trim_reg <= trim_factory;
      trim_loaded_reg <= 1'b1;
    end else if (wr_trim) begin
      // larger code means slower oscillator, applied in the analog trim
      trim_reg <= sfr_wdata[6:0];
      dither_reg <= sfr_wdata[`SCD_BIT_DITHER];
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rdata_next = 8'h00;
    case (sfr_addr)
      `SCD_ADDR_SRC_DIV: begin
        rdata_next = {div_ready, div_req_reg, 1'b0, src_req_reg};
      end
      `SCD_ADDR_IOSC_CTL: begin
        rdata_next = {osc_on_reg, freq_rdy_reg, `SCD_IOSC_RSVD};
      end
      `SCD_ADDR_IOSC_TRIM: begin
        rdata_next = {dither_reg, trim_reg};
      end
      default: begin
        rdata_next = 8'h00;
      end
    endcase
  end

  // read data, held until the next read
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h00;
    end else if (sfr_rd) begin
      rdata_reg <= rdata_next;
    end
  end

  // output copies, each from its own flop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sysclk_src_idx <= `SCD_SRC_IDX_LP;
    end else begin
      sysclk_src_idx <= cur_src_reg;
    end
  end

  // outputs straight from their flops
  assign sfr_rdata = rdata_reg;
  assign sysclk_out = sysclk_reg;
  assign osc_int_on = osc_on_reg;
  assign osc_int_trim = trim_reg;
  assign osc_dither_en = dither_reg;

endmodule : scd_top

// file: hdl/scd_defs.svh
`ifndef SCD_DEFS_SVH
`define SCD_DEFS_SVH

`define SCD_ADDR_SRC_DIV 8'hA9
`define SCD_ADDR_IOSC_CTL 8'hB2
`define SCD_ADDR_IOSC_TRIM 8'hB3

`define SCD_SRC_DIV_RESET 8'h34
`define SCD_IOSC_CTL_RESET 8'h0F
`define SCD_DIV_RESET 3'h3
`define SCD_SRC_RESET 3'h4
`define SCD_IOSC_RSVD 6'h0F
`define SCD_TRIM_PRELOAD 7'h40

`define SCD_BIT_DIV_READY 7
`define SCD_POS_DIV 4
`define SCD_BIT_UNUSED 3
`define SCD_POS_SRC 0
`define SCD_BIT_IOSC_ON 7
`define SCD_BIT_IOSC_FRDY 6
`define SCD_BIT_DITHER 7

`define SCD_SRC_CODE_INT 3'h0
`define SCD_SRC_CODE_EXT 3'h1
`define SCD_SRC_CODE_RTC 3'h3
`define SCD_SRC_CODE_LP 3'h4

`define SCD_SRC_IDX_INT 2'h0
`define SCD_SRC_IDX_EXT 2'h1
`define SCD_SRC_IDX_RTC 2'h2
`define SCD_SRC_IDX_LP 2'h3

`define SCD_DIV_MAX_SRC_CYCLES 128

`endif

// file: hdl/scd_pkg.sv
package scd_pkg;

  typedef enum logic [1:0] {
    sw_run,
    sw_drain_old,
    sw_wait_new
  } scd_sw_state_t;

  typedef logic [2:0] scd_div_code_t;
  typedef logic [2:0] scd_src_code_t;
  typedef logic [1:0] scd_src_idx_t;

endpackage : scd_pkg

// file: hdl/scd_sync3.sv
`timescale 1ns/1ps
// three-stage synchroniser; filtered level moves once stages two and three agree
module scd_sync3 (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic din,
  output logic level,
  output logic change
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic change_reg;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      level_reg <= 1'b0;
      change_reg <= 1'b0;
    end else begin
      change_reg <= (s2_reg == s3_reg) && (s3_reg != level_reg);
      if (s2_reg == s3_reg) begin
        level_reg <= s3_reg;
      end
    end
  end

  assign level = level_reg;
  assign change = change_reg;

endmodule : scd_sync3

// file: tb/scd_top_asserts.sv
`timescale 1ns/1ps
module scd_top_asserts (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [6:0] trim_factory,
  input wire logic sysclk_out,
  input wire logic [1:0] sysclk_src_idx,
  input wire logic osc_int_on,
  input wire logic [6:0] osc_int_trim,
  input wire logic osc_dither_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [2:0] src_req_reg;
  logic [2:0] div_req_reg;
  logic src_ok;
  logic [1:0] src_exp;
  // last requested source and divide codes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      src_req_reg <= 3'h4;
      div_req_reg <= 3'h3;
    end else if (sfr_wr && sfr_addr == 8'hA9) begin
      src_req_reg <= sfr_wdata[2:0];
      div_req_reg <= sfr_wdata[6:4];
    end
  end
  always_comb begin
    src_ok = 1'b1;
    src_exp = 2'h0;
    case (src_req_reg)
      3'h0: src_exp = 2'h0;
      3'h1: src_exp = 2'h1;
      3'h3: src_exp = 2'h2;
      3'h4: src_exp = 2'h3;
      default: src_ok = 1'b0;
    endcase
  end
  chk_trim_strap: assert property (
    $past(arst_n) && !$past(arst_n, 2) |-> osc_int_trim == trim_factory && !osc_dither_en)
    else $error("trim not loaded from strap");
  chk_trim_write: assert property (
    sfr_wr && sfr_addr == 8'hB3 |=> {osc_dither_en, osc_int_trim} == $past(sfr_wdata))
    else $error("trim write lost");
  chk_osc_enable: assert property (
    sfr_wr && sfr_addr == 8'hB2 |=> osc_int_on == $past(sfr_wdata[7]))
    else $error("enable write lost");
  chk_unused_zero: assert property (
    sfr_rd && sfr_addr == 8'hA9 |=> !sfr_rdata[3])
    else $error("unused bit reads one");
  chk_ctl_reserved: assert property (
    sfr_rd && sfr_addr == 8'hB2 |=> sfr_rdata[5:0] == 6'h0F)
    else $error("reserved bits wrong");
  chk_freq_ready: assert property (
    sfr_rd && sfr_addr == 8'hB2 && !osc_int_on |=> !sfr_rdata[6])
    else $error("ready while disabled");
  chk_div_clear: assert property (
    sfr_wr && sfr_addr == 8'hA9 && sfr_wdata[6:4] != div_req_reg ##1
    sfr_rd && sfr_addr == 8'hA9 |=> !sfr_rdata[7])
    else $error("ready not cleared");
  chk_src_map: assert property (
    $changed(sysclk_src_idx) |-> src_ok && sysclk_src_idx == src_exp)
    else $error("wrong source picked");
  chk_switch_low: assert property (
    $changed(sysclk_src_idx) |-> !sysclk_out && !$past(sysclk_out))
    else $error("switch while clock high");
endmodule : scd_top_asserts

bind scd_top scd_top_asserts scd_top_asserts_inst (.mclk(mclk), .arst_n(arst_n),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .trim_factory(trim_factory), .sysclk_out(sysclk_out),
  .sysclk_src_idx(sysclk_src_idx), .osc_int_on(osc_int_on), .osc_int_trim(osc_int_trim),
  .osc_dither_en(osc_dither_en));

// file: tb/scd_top_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module scd_top_test;
  logic mclk, arst_n, sfr_wr, sfr_rd, settled, oi, oe, ort, ol, sclk, on, dith;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  logic [1:0] src_idx;
  logic [6:0] trim;
  int failures = 0;
  int comparisons = 0;
  int k, n, c;
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h4, 3'h0};
  logic [1:0] idxs [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
  scd_top scd_top_inst (.mclk(mclk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .osc_int_in(oi),
    .osc_ext_in(oe), .osc_rtc_in(ort), .osc_lp_in(ol), .osc_int_settled(settled),
    .trim_factory(7'h2A), .sysclk_out(sclk), .sysclk_src_idx(src_idx), .osc_int_on(on),
    .osc_int_trim(trim), .osc_dither_en(dith));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // oscillator edges land on falling mclk edges, away from sampling
  always #20 oi = ~oi;
  always #28 oe = ~oe;
  always #100 ort = ~ort;
  always #16 ol = ~ol;
  task summarize;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // strobes stay up between back-to-back calls; rest drops them
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_rd = 1'b0;
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge mclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    sfr_wr = 1'b0;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge mclk);
    d = sfr_rdata;
  endtask : rd
  task automatic rest;
    {sfr_wr, sfr_rd} = 2'b00;
    @(negedge mclk);
  endtask : rest
  task automatic till(input logic v);
    for (c = 0; sclk !== v; c++) begin
      if (c == 3000) begin failures++; summarize(); end
      @(negedge mclk);
    end
  endtask : till
  initial begin
    {arst_n, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, settled} = '0;
    {oi, oe, ort, ol} = '0;
    repeat (20) @(negedge mclk);
    arst_n = 1'b1;
    repeat (2) @(negedge mclk);
    rd(8'hA9); `CHK("src_div", 8'hB4, d)
    rd(8'hB2); `CHK("osc_ctl", 8'h0F, d)
    rd(8'hB3); `CHK("trim_reg", 8'h2A, d)
    rd(8'h55); `CHK("unmapped", 8'h00, d)
    wr(8'hB2, 8'h8F); rd(8'hB2); `CHK("osc_on", 8'h8F, d)
    rest();
    settled = 1'b1;
    repeat (8) @(negedge mclk);
    rd(8'hB2); `CHK("freq_rdy", 8'hCF, d)
    wr(8'hB2, 8'h0F); rd(8'hB2); `CHK("osc_off", 8'h0F, d)
    `CHK("on_pin", 1'b0, on)
    wr(8'hB3, 8'hA5); `CHK("dither", 1'b1, dith)
    `CHK("trim_pin", 7'h25, trim)
    wr(8'hA9, 8'h08); rd(8'hA9); `CHK("unused", 7'h00, d[6:0])
    for (k = 0; k < 6; k++) begin
      wr(8'hA9, {5'h00, codes[k]});
      rest();
      repeat (150) @(negedge mclk);
      `CHK("src_idx", idxs[k], src_idx)
    end
    // descending so every write changes the divide; ends at divide by one
    for (k = 7; k >= 0; k--) begin
      wr(8'hA9, {1'b0, k[2:0], 4'h0}); rd(8'hA9); `CHK("rdy_clr", 1'b0, d[7])
      for (n = 0; d[7] !== 1'b1; n++) begin
        if (n == 2000) begin failures++; summarize(); end
        rd(8'hA9);
      end
      rest();
      till(1'b1); till(1'b0); till(1'b1); till(1'b0);
      n = c;
      till(1'b1);
      `CHK("period", 10 << k, n + c)
    end
    summarize();
  end
endmodule : scd_top_test
